// [cpdd_pkg.sv]
// package for the coprocessor data operation decoder: instruction fields,
// condition codes, trap vectors, modes and carrier structs.
// assumes a 32-bit instruction word and a flag nibble n,z,c,v from the core.
// Operation
// [RL1] a coprocessor data operation executes only when its condition field in bits 31:28 passes the current flags.
// [RL2] the class is bits 27:24 equal to 1110 with bit 4 clear, and only bits 31:24 and 4 matter to the core.
// [RL3] fields split as opcode 23:20, first operand 19:16, destination 15:12, number 11:8, aux 7:5, second operand 3:0.
// [RL4] with no coprocessor present, every coprocessor instruction takes the undefined-instruction trap.
// [RL5] each coprocessor owns a number 0 to 15 and ignores instructions carrying another number.
// [RL6] the core expects no result and never stalls waiting for a data operation to finish.
// [RL7] a data operation costs one sequential cycle plus one internal cycle per busy-wait cycle.
// [RL8] by convention the coprocessor runs the opcode, qualified by aux, on both operands into the destination.
// [RL9] the low comment field of a software trap instruction never alters hardware behaviour.
// [RL10] a software trap forces the program counter to 0x08 and saves the status into the supervisor saved status.
// [RL11] the undefined trap enters undefined mode at its usual vector, saving return address and status.
package cpdd_pkg;

    // ======================================================================
    // instruction fields
    // ======================================================================
    localparam int COND_HI    = 31;
    localparam int COND_LO    = 28;
    localparam int CLASS_HI   = 27;
    localparam int CLASS_LO   = 24;
    localparam int OPC_HI     = 23;
    localparam int OPC_LO     = 20;
    localparam int CRN_HI     = 19;
    localparam int CRN_LO     = 16;
    localparam int CRD_HI     = 15;
    localparam int CRD_LO     = 12;
    localparam int CPN_HI     = 11;
    localparam int CPN_LO     = 8;
    localparam int AUX_HI     = 7;
    localparam int AUX_LO     = 5;
    localparam int DOP_BIT    = 4;
    localparam int CRM_HI     = 3;
    localparam int CRM_LO     = 0;

    localparam logic [3:0] CLASS_CDP   = 4'h_e;
    localparam logic [3:0] CLASS_SWT   = 4'h_f;
    localparam logic [2:0] CLASS_CPX_HI = 3'h_6;   // transfers, bits 27:25 = 110

    // ======================================================================
    // condition codes
    // ======================================================================
    localparam logic [3:0] CC_EQ = 4'h_0;
    localparam logic [3:0] CC_NE = 4'h_1;
    localparam logic [3:0] CC_CS = 4'h_2;
    localparam logic [3:0] CC_CC = 4'h_3;
    localparam logic [3:0] CC_MI = 4'h_4;
    localparam logic [3:0] CC_PL = 4'h_5;
    localparam logic [3:0] CC_VS = 4'h_6;
    localparam logic [3:0] CC_VC = 4'h_7;
    localparam logic [3:0] CC_HI = 4'h_8;
    localparam logic [3:0] CC_LS = 4'h_9;
    localparam logic [3:0] CC_GE = 4'h_a;
    localparam logic [3:0] CC_LT = 4'h_b;
    localparam logic [3:0] CC_GT = 4'h_c;
    localparam logic [3:0] CC_LE = 4'h_d;
    localparam logic [3:0] CC_AL = 4'h_e;

    // ======================================================================
    // trap vectors and modes
    // ======================================================================
    localparam logic [31:0] VEC_UNDEF = 32'h_0000_0004;
    localparam logic [31:0] VEC_SWT   = 32'h_0000_0008;
    localparam logic [31:0] PC_STEP   = 32'h_0000_0004;
    localparam logic [4:0]  MODE_SVC  = 5'h_13;
    localparam logic [4:0]  MODE_UND  = 5'h_1b;
    localparam logic [31:0] ZERO_W    = 32'h_0000_0000;
    localparam logic [7:0]  ZERO_CNT  = 8'h_00;
    localparam logic [7:0]  CNT_ONE   = 8'h_01;

    // ======================================================================
    // carriers
    // ======================================================================
    typedef struct packed {
        logic [3:0] opcode;
        logic [3:0] first_opnd;
        logic [3:0] dest;
        logic [3:0] cp_num;
        logic [2:0] aux;
        logic [3:0] second_opnd;
    } cpdd_fields_t;

    typedef struct packed {
        logic        taken;
        logic [31:0] vector;
        logic [4:0]  mode;
        logic [31:0] link;
        logic [31:0] saved_status;
    } cpdd_trap_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_SEQ   = 3'b010,
        ST_BUSY  = 3'b100
    } cpdd_state_t;

endpackage : cpdd_pkg

// [cpdd_cond_check.sv]
// condition evaluator: compares a condition field with the flag nibble.
// assumes flags ordered n,z,c,v from bit 3 down.
`timescale 1ns/100ps
module cpdd_cond_check
    import cpdd_pkg::*;
(
    input  wire logic [3:0] cond_i,
    input  wire logic [3:0] flags_i,
    output logic            pass_o
);
    logic n, z, c, v;
    assign n = flags_i[3];
    assign z = flags_i[2];
    assign c = flags_i[1];
    assign v = flags_i[0];

    always_comb begin
        case (cond_i) // RL1
            CC_EQ:   pass_o = z;
            CC_NE:   pass_o = !z;
            CC_CS:   pass_o = c;
            CC_CC:   pass_o = !c;
            CC_MI:   pass_o = n;
            CC_PL:   pass_o = !n;
            CC_VS:   pass_o = v;
            CC_VC:   pass_o = !v;
            CC_HI:   pass_o = c && !z;
            CC_LS:   pass_o = !c || z;
            CC_GE:   pass_o = n == v;
            CC_LT:   pass_o = n != v;
            CC_GT:   pass_o = !z && (n == v);
            CC_LE:   pass_o = z || (n != v);
            CC_AL:   pass_o = 1'b1;
            default: pass_o = 1'b0;   // never code: treat as not executed
        endcase
    end
endmodule : cpdd_cond_check

// [cpdd_decode.sv]
// coprocessor data operation decoder with trap generation.
// assumes one instruction offered per valid pulse, with its address,
// the current flags and the current status word, all synchronous to ref_clk_i.
`timescale 1ns/100ps
module cpdd_decode
    import cpdd_pkg::*;
(
    input  wire logic         ref_clk_i,
    input  wire logic         nrst_i,
    input  wire logic         instr_valid_i,
    input  wire logic [31:0]  instr_i,
    input  wire logic [31:0]  instr_addr_i,
    input  wire logic [3:0]   flags_i,
    input  wire logic [31:0]  status_i,
    input  wire logic         cp_busy_i,
    output logic              ready_o,
    output logic              done_o,
    output logic              is_cdp_o,
    output logic              skipped_o,
    output cpdd_fields_t      fields_o,
    output cpdd_trap_t        trap_o,
    output logic [7:0]        cycles_o
);

    // ======================================================================
    // decode
    // ======================================================================
    logic         cond_pass;
    logic         cls_cdp;
    logic         cls_cpx;
    logic         cls_swt;
    cpdd_fields_t fld;

    cpdd_cond_check u_cond (
        .cond_i  (instr_i[COND_HI:COND_LO]),
        .flags_i (flags_i),
        .pass_o  (cond_pass)
    );

    // only the top byte and bit 4 are looked at for the class
    assign cls_cdp = (instr_i[CLASS_HI:CLASS_LO] == CLASS_CDP) && !instr_i[DOP_BIT]; // RL2
    assign cls_cpx = (instr_i[CLASS_HI:CLASS_LO+1] == CLASS_CPX_HI) ||
                     ((instr_i[CLASS_HI:CLASS_LO] == CLASS_CDP) && instr_i[DOP_BIT]);
    // comment field below bit 24 is not part of this decode at all
    assign cls_swt = instr_i[CLASS_HI:CLASS_LO] == CLASS_SWT; // RL9

    always_comb begin
        fld.opcode      = instr_i[OPC_HI:OPC_LO]; // RL3
        fld.first_opnd  = instr_i[CRN_HI:CRN_LO];
        fld.dest        = instr_i[CRD_HI:CRD_LO];
        fld.cp_num      = instr_i[CPN_HI:CPN_LO]; // RL5
        fld.aux         = instr_i[AUX_HI:AUX_LO]; // RL8
        fld.second_opnd = instr_i[CRM_HI:CRM_LO];
    end

    // ======================================================================
    // cycle accounting: one sequential cycle, then internal cycles
    // while the coprocessor holds busy
    // ======================================================================
    cpdd_state_t state_r, state_nxt;
    logic [7:0]  cnt_r;
    logic        accept;

    assign accept = instr_valid_i && (state_r == ST_IDLE);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (accept && cond_pass && cls_cdp) begin
                    state_nxt = ST_SEQ;
                end
            end
            ST_SEQ: begin
                state_nxt = cp_busy_i ? ST_BUSY : ST_IDLE; // RL7
            end
            ST_BUSY: begin
                // never waits for a result, only for the busy-wait
                state_nxt = cp_busy_i ? ST_BUSY : ST_IDLE; // RL6
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_r <= ZERO_CNT;
        end else if (accept) begin
            cnt_r <= CNT_ONE;   // the sequential cycle
        end else if (state_r == ST_BUSY || (state_r == ST_SEQ && cp_busy_i)) begin
            cnt_r <= cnt_r + CNT_ONE; // RL7
        end
    end

    // ======================================================================
    // outputs
    // ======================================================================
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ready_o <= 1'b1;
            done_o  <= 1'b0;
        end else begin
            ready_o <= state_nxt == ST_IDLE;
            done_o  <= (state_r != ST_IDLE) && (state_nxt == ST_IDLE);
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cycles_o <= ZERO_CNT;
        end else if ((state_r != ST_IDLE) && (state_nxt == ST_IDLE)) begin
            cycles_o <= cnt_r;
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            is_cdp_o  <= 1'b0;
            skipped_o <= 1'b0;
            fields_o  <= '0;
        end else begin
            is_cdp_o  <= accept && cls_cdp;
            skipped_o <= accept && !cond_pass; // RL1
            if (accept && cls_cdp) begin
                fields_o <= fld;
            end
        end
    end

    // no coprocessor exists, so every coprocessor class traps to undefined
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            trap_o <= '0;
        end else begin
            trap_o.taken <= 1'b0;
            if (accept && cond_pass && (cls_cdp || cls_cpx)) begin
                trap_o.taken        <= 1'b1; // RL4
                trap_o.vector       <= VEC_UNDEF; // RL11
                trap_o.mode         <= MODE_UND;
                trap_o.link         <= instr_addr_i + PC_STEP;
                trap_o.saved_status <= status_i;
            end else if (accept && cond_pass && cls_swt) begin
                trap_o.taken        <= 1'b1;
                trap_o.vector       <= VEC_SWT; // RL10
                trap_o.mode         <= MODE_SVC;
                trap_o.link         <= instr_addr_i + PC_STEP;
                trap_o.saved_status <= status_i; // RL10
            end
        end
    end

endmodule : cpdd_decode

// [cpdd_decode_chk.sv]
// checker for the coprocessor data operation decoder, ports only.
// assumes cpdd_pkg is compiled first; bound onto every cpdd_decode.
`timescale 1ns/100ps
module cpdd_decode_chk
    import cpdd_pkg::*;
(
    input wire logic         ref_clk_i,
    input wire logic         nrst_i,
    input wire logic         instr_valid_i,
    input wire logic [31:0]  instr_i,
    input wire logic [31:0]  instr_addr_i,
    input wire logic [3:0]   flags_i,
    input wire logic [31:0]  status_i,
    input wire logic         cp_busy_i,
    input wire logic         ready_o,
    input wire logic         done_o,
    input wire logic         is_cdp_o,
    input wire logic         skipped_o,
    input wire cpdd_fields_t fields_o,
    input wire cpdd_trap_t   trap_o,
    input wire logic [7:0]   cycles_o
);
    // =========================================
    // helpers
    // =========================================
    logic        took_c;
    logic        cdp_c;
    logic        swt_c;
    logic        run_c;
    logic [22:0] fld_c;
    assign took_c = instr_valid_i && ready_o;
    assign cdp_c  = instr_i[CLASS_HI:CLASS_LO] == CLASS_CDP && !instr_i[DOP_BIT];
    assign swt_c  = instr_i[CLASS_HI:CLASS_LO] == CLASS_SWT;
    assign run_c  = is_cdp_o && !skipped_o;
    assign fld_c  = {instr_i[23:8], instr_i[7:5], instr_i[3:0]};
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);

    // =========================================
    // assertions
    // =========================================
    a_class_decode: assert property (took_c |=> is_cdp_o == $past(cdp_c)) else $error("class flag wrong");
    a_idle_quiet: assert property (!ready_o |=> !is_cdp_o && !skipped_o && !trap_o.taken) else $error("busy took");
    a_fields_split: assert property (run_c |-> fields_o == $past(fld_c)) else $error("fields wrong");
    a_skip_no_trap: assert property (skipped_o |-> !trap_o.taken) else $error("skipped op trapped");
    a_cdp_undef: assert property (run_c |-> trap_o.taken && trap_o.vector == VEC_UNDEF && trap_o.mode == MODE_UND)
        else $error("no undefined trap");
    a_swt_vector: assert property (took_c && swt_c ##1 !skipped_o |-> trap_o.taken && trap_o.vector == VEC_SWT
        && trap_o.mode == MODE_SVC) else $error("software trap wrong");
    a_trap_link: assert property (trap_o.taken |-> trap_o.link == $past(instr_addr_i) + PC_STEP
        && trap_o.saved_status == $past(status_i)) else $error("link or status wrong");
    a_done_plain: assert property (run_c && !cp_busy_i |=> done_o && cycles_o == 8'h01) else $error("late done");
    a_busy_wait: assert property (run_c && cp_busy_i |=> !done_o && !ready_o) else $error("done during busy");
    a_done_ready: assert property (done_o |-> ready_o && !$past(ready_o)) else $error("ready not back");
    c_busy_op: cover property (done_o && cycles_o > 8'h01);
    c_skip: cover property (skipped_o);
    c_swt: cover property (trap_o.taken && trap_o.mode == MODE_SVC);
endmodule : cpdd_decode_chk

bind cpdd_decode cpdd_decode_chk chk_u (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .instr_valid_i(instr_valid_i),
    .instr_i(instr_i), .instr_addr_i(instr_addr_i), .flags_i(flags_i), .status_i(status_i), .cp_busy_i(cp_busy_i),
    .ready_o(ready_o), .done_o(done_o), .is_cdp_o(is_cdp_o), .skipped_o(skipped_o), .fields_o(fields_o),
    .trap_o(trap_o), .cycles_o(cycles_o));

// [cpdd_decode_tb.sv]
// self-checking bench for the coprocessor data operation decoder.
// assumes cpdd_pkg and the design are compiled first.
`timescale 1ns/100ps
module cpdd_decode_tb
    import cpdd_pkg::*;
;
    logic         ref_clk_i = 1'b0;
    logic         nrst_i, instr_valid_i, cp_busy_i, ready_o, done_o, is_cdp_o, skipped_o;
    logic [31:0]  instr_i, instr_addr_i, status_i, ins;
    logic [3:0]   flags_i;
    logic [7:0]   cycles_o;
    cpdd_fields_t fields_o;
    cpdd_trap_t   trap_o;
    logic [31:0]  seed = 32'h_a4ce_564a;
    int           fails = 0;
    int           check_count = 0;

    cpdd_decode dut_u (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
        .instr_addr_i(instr_addr_i), .flags_i(flags_i), .status_i(status_i), .cp_busy_i(cp_busy_i),
        .ready_o(ready_o), .done_o(done_o), .is_cdp_o(is_cdp_o), .skipped_o(skipped_o), .fields_o(fields_o),
        .trap_o(trap_o), .cycles_o(cycles_o));

    always #10 ref_clk_i = ~ref_clk_i;

    // =========================================
    // helpers
    // =========================================
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        for (int i = 0; i < 32; i++) s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
        return s;
    endfunction : lfsr

    // odd codes invert the even one; so 1111 falls out as never
    function automatic logic cond_ok(input logic [3:0] c, input logic [3:0] f);
        logic r;
        case (c[3:1])
            3'h0: r = f[2];
            3'h1: r = f[1];
            3'h2: r = f[3];
            3'h3: r = f[0];
            3'h4: r = f[1] & ~f[2];
            3'h5: r = f[3] == f[0];
            3'h6: r = ~f[2] & (f[3] == f[0]);
            default: r = 1'b1;
        endcase
        return r ^ c[0];
    endfunction : cond_ok

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic issue(input logic [31:0] w, input logic [3:0] fl, input int b);
        logic        pass, coproc_data_operation, swt, trp;
        logic [31:0] adr, st;
        int          n;
        pass = cond_ok(w[31:28], fl);
        coproc_data_operation = w[27:24] == CLASS_CDP && !w[4];
        swt = w[27:24] == CLASS_SWT;
        trp = pass && (swt || w[27:24] == CLASS_CDP || w[27:25] == CLASS_CPX_HI);
        seed = lfsr(seed);
        adr = {seed[29:0], 2'b00};
        st = seed ^ 32'h_5a5a_0f0f;
        @(posedge ref_clk_i);
        instr_valid_i <= 1'b1;
        instr_i <= w;
        instr_addr_i <= adr;
        flags_i <= fl;
        status_i <= st;
        cp_busy_i <= b > 0;
        @(posedge ref_clk_i);
        instr_valid_i <= 1'b0;
        instr_i <= ~w;
        #1;
        chk(is_cdp_o, coproc_data_operation);
        chk(skipped_o, !pass);
        chk(trap_o.taken, trp);
        chk(ready_o, !(pass && coproc_data_operation));
        if (trp) begin
            chk(trap_o.vector, swt ? VEC_SWT : VEC_UNDEF);
            chk(trap_o.mode, swt ? MODE_SVC : MODE_UND);
            chk(trap_o.link, adr + 32'h_0000_0004);
            chk(trap_o.saved_status, st);
        end
        if (pass && coproc_data_operation) begin
            chk(fields_o, {w[23:8], w[7:5], w[3:0]});
            n = 0;
            while (done_o !== 1'b1 && n < 40) begin
                @(posedge ref_clk_i);
                n++;
                if (n >= b) cp_busy_i <= 1'b0;
                // re-offer the op while busy: it must be refused
                instr_valid_i <= n < b;
                instr_i <= w;
                #1;
                chk({trap_o.taken, is_cdp_o, skipped_o}, 3'h0);
            end
            chk(n, b + 1);
            chk(cycles_o, b + 1);
        end
    endtask : issue

    task automatic complete_run;
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : complete_run

    // =========================================
    // sequence
    // =========================================
    initial begin
        nrst_i = 1'b0;
        {instr_valid_i, cp_busy_i, instr_i, instr_addr_i, status_i, flags_i} = '0;
        repeat (4) @(posedge ref_clk_i);
        chk(ready_o, 1'b1);
        nrst_i <= 1'b1;
        issue(32'h_ee0a_1203, 4'h_0, 0);
        issue(32'h_fe0a_1203, 4'h_f, 0);
        issue(32'h_0e12_3406, 4'h_4, 5);
        issue(32'h_1f12_3456, 4'h_4, 0);
        issue(32'h_efff_ffff, 4'h_0, 0);
        issue(32'h_ec12_3456, 4'h_0, 0);
        issue(32'h_ee12_3456, 4'h_0, 0);
        for (int i = 0; i < 300; i++) begin
            seed = lfsr(seed);
            ins = seed;
            if (seed[1:0] != 2'h3) ins[27:24] = seed[1] ? CLASS_SWT : CLASS_CDP;
            if (seed[1:0] == 2'h0) ins[4] = 1'b0;
            seed = lfsr(seed);
            issue(ins, seed[3:0], int'(seed[6:4]));
        end
        complete_run;
    end

    initial begin
        #400_000;
        fails++;
        complete_run;
    end
endmodule : cpdd_decode_tb
